// File: core/rbl_defines.svh
// constants of the radio block loopback link: widths, header fields and timing
`ifndef RBL_DEFINES_SVH
`define RBL_DEFINES_SVH

`define RBL_DW          32
`define RBL_NTS         8
`define RBL_PT_OFF_BIT  0
`define RBL_PT_OPT      2'h2
`define RBL_CLK_NS      5
`define RBL_TT02_NS     2000
`define RBL_TT02_CYC    ((`RBL_TT02_NS + `RBL_CLK_NS - 1) / `RBL_CLK_NS)
`define RBL_TT03_NS     1000
`define RBL_TT03_CYC    ((`RBL_TT03_NS + `RBL_CLK_NS - 1) / `RBL_CLK_NS)
`define RBL_BLK_NS      640
`define RBL_BLK_CYC     ((`RBL_BLK_NS + `RBL_CLK_NS - 1) / `RBL_CLK_NS)
`define RBL_PRBS_SEED   15'h0001

`endif

// File: core/rbl_pkg.sv
// types shared by both ends of the radio block loopback link
package rbl_pkg;
`include "rbl_defines.svh"
    typedef logic [`RBL_DW-1:0]  rbl_word_t;
    typedef logic [2:0]          rbl_tn_t;
    typedef logic [1:0]          rbl_ptype_t;
    typedef logic [`RBL_NTS-1:0] rbl_mask_t;
    typedef enum logic [1:0] {MS_IDLE, MS_REQ, MS_LOOP} rbl_ms_state_t;
    typedef enum logic [1:0] {SS_IDLE, SS_TT02, SS_TT03, SS_RUN} rbl_ss_state_t;
endpackage : rbl_pkg

// File: core/rbl_link_if.sv
// radio link between mobile test logic and the system simulator
`timescale 1ns/1ps
interface rbl_link_if (
    input wire logic clk,
    input wire logic rstn
);
    import rbl_pkg::*;
    logic       blk_tick;
    logic       start_cmd;
    logic       ul_req;
    logic       ul_assign;
    logic       tbf_release;
    logic       dl_valid;
    rbl_tn_t    dl_tn;
    logic       dl_ctrl;
    rbl_ptype_t dl_ptype;
    logic       dl_hdr_ok;
    rbl_word_t  dl_data;
    logic       ul_valid;
    rbl_tn_t    ul_tn;
    logic       ul_looped;
    rbl_word_t  ul_data;

    modport ms (
        input  blk_tick, start_cmd, ul_assign, tbf_release,
        input  dl_valid, dl_tn, dl_ctrl, dl_ptype, dl_hdr_ok, dl_data,
        output ul_req, ul_valid, ul_tn, ul_looped, ul_data
    );
    modport ss (
        output blk_tick, start_cmd, ul_assign, tbf_release,
        output dl_valid, dl_tn, dl_ctrl, dl_ptype, dl_hdr_ok, dl_data,
        input  ul_req, ul_valid, ul_tn, ul_looped, ul_data
    );
endinterface : rbl_link_if

// File: core/rbl_slot_map.sv
// maps each uplink timeslot onto the downlink timeslot whose block it carries
`timescale 1ns/1ps
module rbl_slot_map
    import rbl_pkg::*;
(
    input  wire rbl_pkg::rbl_mask_t dl_mask,
    input  wire rbl_pkg::rbl_tn_t   ts_offset,
    input  wire logic               multislot_en,
    output rbl_pkg::rbl_tn_t        ul_src [`RBL_NTS]
);
    rbl_tn_t    ordered [`RBL_NTS];
    logic [3:0] cnt;

    // ---------------------------------------------------------------
    // downlink order: from the offset upward, wrapping past slot 7
    // ---------------------------------------------------------------
    always_comb begin
        rbl_tn_t tn;
        tn  = '0;
        cnt = 4'h0;
        for (int i = 0; i < `RBL_NTS; i++) begin
            ordered[i] = ts_offset;
        end
        for (int i = 0; i < `RBL_NTS; i++) begin
            tn = 3'(ts_offset + 3'(i));
            if (dl_mask[tn]) begin
                ordered[cnt[2:0]] = tn;
                cnt = 4'(cnt + 4'h1);
            end
        end
    end

    // ---------------------------------------------------------------
    // uplink index u always counts from slot 0
    // ---------------------------------------------------------------
    genvar u;
    generate
        for (u = 0; u < `RBL_NTS; u++) begin : g_map
            always_comb begin
                if (!multislot_en || cnt <= 4'h1) begin
                    ul_src[u] = ordered[0];
                end else if (4'(u) < cnt) begin
                    ul_src[u] = ordered[u];
                end else begin
                    ul_src[u] = ordered[3'(cnt - 4'h1)];
                end
            end
        end
    endgenerate
endmodule : rbl_slot_map

// File: core/rbl_ms.sv
// mobile-station end: switched radio block loopback with sub-mode control
//
// Notes on behaviour
// - n-th downlink slot goes to n-th uplink
// - surplus uplink slots copy last mapped slot
// - single downlink slot fills every uplink slot
// - downlink counted from offset, wrapping 7 to 0
// - uplink slots always counted from zero
// - start command requests unacknowledged uplink TBF
// - simulator times request, then assigns uplink
// - simulator waits TT03, then sends blocks
// - data blocks withheld from LLC in loopback
// - TBFs stay open, expiry timers disabled
// - loopback starts in ON sub-mode
// - payload type bit 0 selects ON/OFF
// - code 10 flags optional downlink octet
// - request for current sub-mode is ignored
// - mode persists until termination
// - ON loops every block next block period
// - ON also decodes, good headers to RLC/MAC
// - ON sends no own uplink traffic
// - OFF loops only blocks taken while still ON, own traffic allowed
// - TBF control messages obeyed in both sub-modes
// - ends on TBF release or T3190 expiry
// - on end stop uplink, discard, go idle
// - simulator payload from long pseudorandom generator
`timescale 1ns/1ps
module rbl_ms
    import rbl_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rstn,
    rbl_link_if.ms                  link,
    input  wire rbl_pkg::rbl_mask_t dl_ts_mask,
    input  wire rbl_pkg::rbl_mask_t ul_ts_mask,
    input  wire rbl_pkg::rbl_tn_t   ts_offset,
    input  wire logic               multislot_en,
    input  wire logic               t3190_expired,
    input  wire logic               own_valid,
    input  wire rbl_pkg::rbl_word_t own_data,
    output logic                    own_ready,
    output logic                    rlcmac_valid,
    output rbl_pkg::rbl_word_t      rlcmac_data,
    output logic                    rlcmac_ctrl,
    output logic                    rlcmac_opt,
    output logic                    llc_valid,
    output rbl_pkg::rbl_word_t      llc_data,
    output logic                    loop_active,
    output logic                    submode_on,
    output logic                    timers_disable,
    output logic                    packet_idle
);
    import rbl_pkg::*;

    // ---------------------------------------------------------------
    // header decode helpers
    // ---------------------------------------------------------------
    function automatic logic pt_wants_on(input rbl_ptype_t pt);
        return !pt[`RBL_PT_OFF_BIT];
    endfunction : pt_wants_on

    function automatic logic pt_has_opt(input rbl_ptype_t pt);
        return pt == `RBL_PT_OPT;
    endfunction : pt_has_opt

    function automatic rbl_tn_t first_slot(input rbl_mask_t m);
        rbl_tn_t r;
        r = '0;
        for (int i = `RBL_NTS - 1; i >= 0; i--) begin
            if (m[i]) r = 3'(i);
        end
        return r;
    endfunction : first_slot

    rbl_ms_state_t state_ff;
    logic          submode_on_ff;
    logic          ul_req_ff;
    rbl_word_t     rx_buf_ff [`RBL_NTS];
    rbl_mask_t     rx_have_ff;
    rbl_word_t     tx_buf_ff [`RBL_NTS];
    rbl_mask_t     tx_have_ff;
    logic [3:0]    seq_ff;
    logic          ul_valid_ff;
    rbl_tn_t       ul_tn_ff;
    logic          ul_looped_ff;
    rbl_word_t     ul_data_ff;
    logic          rlcmac_valid_ff;
    rbl_word_t     rlcmac_data_ff;
    logic          rlcmac_ctrl_ff;
    logic          rlcmac_opt_ff;
    logic          llc_valid_ff;
    rbl_word_t     llc_data_ff;
    rbl_tn_t       ul_src [`RBL_NTS];

    logic terminate;
    logic looping;
    logic dl_good;
    logic seq_run;
    logic own_go;

    assign terminate = (state_ff != MS_IDLE) && (link.tbf_release || t3190_expired);
    assign looping   = (state_ff == MS_LOOP) && !terminate;
    assign dl_good   = link.dl_valid && link.dl_hdr_ok;
    assign seq_run   = !seq_ff[3];
    // own traffic only in the OFF sub-mode and never inside a loop burst
    assign own_ready = looping && !submode_on_ff && !seq_run;
    assign own_go    = own_valid && own_ready;

    rbl_slot_map u_map (
        .dl_mask      (dl_ts_mask),
        .ts_offset    (ts_offset),
        .multislot_en (multislot_en),
        .ul_src       (ul_src)
    );

    // ---------------------------------------------------------------
    // mode control
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff  <= MS_IDLE;
            ul_req_ff <= 1'b0;
        end else begin
            ul_req_ff <= 1'b0;
            case (state_ff)
                MS_IDLE: begin
                    if (link.start_cmd) begin
                        state_ff  <= MS_REQ;
                        ul_req_ff <= 1'b1;
                    end
                end
                MS_REQ: begin
                    if (terminate) state_ff <= MS_IDLE;
                    else if (link.ul_assign) state_ff <= MS_LOOP;
                end
                MS_LOOP: begin
                    // stays here in either sub-mode until ended
                    if (terminate) state_ff <= MS_IDLE;
                end
                default: state_ff <= MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            submode_on_ff <= 1'b0;
        end else if (terminate) begin
            submode_on_ff <= 1'b0;
        end else if (state_ff == MS_IDLE && link.start_cmd) begin
            submode_on_ff <= 1'b1;
        end else if (looping && dl_good && link.dl_ctrl) begin
            // writing the same value is the ignore case
            submode_on_ff <= pt_wants_on(link.dl_ptype);
        end
    end

    // ---------------------------------------------------------------
    // raw block capture and hand-over at the block boundary
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_have_ff <= '0;
            tx_have_ff <= '0;
            for (int i = 0; i < `RBL_NTS; i++) begin
                rx_buf_ff[i] <= '0;
                tx_buf_ff[i] <= '0;
            end
        end else if (!looping) begin
            rx_have_ff <= '0;
            tx_have_ff <= '0;
        end else begin
            if (link.blk_tick) begin
                tx_have_ff <= rx_have_ff;
                rx_have_ff <= '0;
                for (int i = 0; i < `RBL_NTS; i++) begin
                    tx_buf_ff[i] <= rx_buf_ff[i];
                end
            end
            // taken before decoding: usf, tfi and header check play no part
            if (link.dl_valid && submode_on_ff) begin
                rx_buf_ff[link.dl_tn]  <= link.dl_data;
                rx_have_ff[link.dl_tn] <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // uplink sequencer: walks the uplink slots once per block period
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seq_ff <= 4'h8;
        end else if (!looping) begin
            seq_ff <= 4'h8;
        end else if (link.blk_tick && (submode_on_ff || rx_have_ff != '0)) begin
            // blocks taken while still ON go back even if OFF came in between
            seq_ff <= 4'h0;
        end else if (seq_run) begin
            seq_ff <= 4'(seq_ff + 4'h1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ul_valid_ff  <= 1'b0;
            ul_tn_ff     <= '0;
            ul_looped_ff <= 1'b0;
            ul_data_ff   <= '0;
        end else begin
            ul_valid_ff <= 1'b0;
            if (looping && seq_run && ul_ts_mask[seq_ff[2:0]]
                && tx_have_ff[ul_src[seq_ff[2:0]]]) begin
                ul_valid_ff  <= 1'b1;
                ul_tn_ff     <= seq_ff[2:0];
                ul_looped_ff <= 1'b1;
                ul_data_ff   <= tx_buf_ff[ul_src[seq_ff[2:0]]];
            end else if (own_go) begin
                ul_valid_ff  <= 1'b1;
                ul_tn_ff     <= first_slot(ul_ts_mask);
                ul_looped_ff <= 1'b0;
                ul_data_ff   <= own_data;
            end
        end
    end

    // ---------------------------------------------------------------
    // decoded path towards rlc/mac and llc
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rlcmac_valid_ff <= 1'b0;
            rlcmac_data_ff  <= '0;
            rlcmac_ctrl_ff  <= 1'b0;
            rlcmac_opt_ff   <= 1'b0;
            llc_valid_ff    <= 1'b0;
            llc_data_ff     <= '0;
        end else begin
            rlcmac_valid_ff <= dl_good;
            // data blocks reach llc only outside the test mode
            llc_valid_ff    <= dl_good && !link.dl_ctrl && state_ff == MS_IDLE;
            if (dl_good) begin
                rlcmac_data_ff <= link.dl_data;
                rlcmac_ctrl_ff <= link.dl_ctrl;
                rlcmac_opt_ff  <= link.dl_ctrl && pt_has_opt(link.dl_ptype);
                llc_data_ff    <= link.dl_data;
            end
        end
    end

    assign link.ul_req    = ul_req_ff;
    assign link.ul_valid  = ul_valid_ff;
    assign link.ul_tn     = ul_tn_ff;
    assign link.ul_looped = ul_looped_ff;
    assign link.ul_data   = ul_data_ff;
    assign rlcmac_valid   = rlcmac_valid_ff;
    assign rlcmac_data    = rlcmac_data_ff;
    assign rlcmac_ctrl    = rlcmac_ctrl_ff;
    assign rlcmac_opt     = rlcmac_opt_ff;
    assign llc_valid      = llc_valid_ff;
    assign llc_data       = llc_data_ff;
    assign loop_active    = state_ff == MS_LOOP;
    assign submode_on     = submode_on_ff;
    assign timers_disable = state_ff != MS_IDLE;
    assign packet_idle    = state_ff == MS_IDLE;
endmodule : rbl_ms

// File: core/rbl_ss.sv
// simulator end: starts the loopback, feeds downlink blocks, collects uplink
`timescale 1ns/1ps
module rbl_ss
    import rbl_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rstn,
    rbl_link_if.ss                   link,
    input  wire logic                start_test,
    input  wire logic                release_test,
    input  wire logic                tx_valid,
    input  wire rbl_pkg::rbl_tn_t    tx_tn,
    input  wire logic                tx_ctrl,
    input  wire rbl_pkg::rbl_ptype_t tx_ptype,
    input  wire rbl_pkg::rbl_word_t  tx_ctrl_data,
    output logic                     tx_ready,
    output logic                     tt02_timeout,
    output logic                     loop_valid,
    output rbl_pkg::rbl_tn_t         loop_tn,
    output logic                     loop_looped,
    output rbl_pkg::rbl_word_t       loop_data
);
    import rbl_pkg::*;

    // 15-bit generator: x^15 + x^14 + 1 has a 32767-bit cycle
    function automatic logic [14:0] prbs_step(input logic [14:0] s);
        logic [14:0] r;
        r = s;
        for (int i = 0; i < `RBL_DW; i++) begin
            r = {r[13:0], r[14] ^ r[13]};
        end
        return r;
    endfunction : prbs_step

    rbl_ss_state_t state_ff;
    logic [15:0]   tmr_ff;
    logic [15:0]   blk_cnt_ff;
    logic [14:0]   prbs_ff;
    logic          start_ff;
    logic          assign_ff;
    logic          release_ff;
    logic          timeout_ff;
    logic          dl_valid_ff;
    rbl_tn_t       dl_tn_ff;
    logic          dl_ctrl_ff;
    rbl_ptype_t    dl_ptype_ff;
    rbl_word_t     dl_data_ff;
    logic          loop_valid_ff;
    rbl_tn_t       loop_tn_ff;
    logic          loop_looped_ff;
    rbl_word_t     loop_data_ff;

    assign tx_ready = state_ff == SS_RUN;

    // ---------------------------------------------------------------
    // procedure: TT02 around the request, TT03 before traffic
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= SS_IDLE;
            tmr_ff     <= '0;
            start_ff   <= 1'b0;
            assign_ff  <= 1'b0;
            release_ff <= 1'b0;
            timeout_ff <= 1'b0;
        end else begin
            start_ff   <= 1'b0;
            assign_ff  <= 1'b0;
            release_ff <= 1'b0;
            tmr_ff     <= 16'(tmr_ff + 16'h1);
            case (state_ff)
                SS_IDLE: begin
                    if (start_test) begin
                        state_ff   <= SS_TT02;
                        start_ff   <= 1'b1;
                        timeout_ff <= 1'b0;
                        tmr_ff     <= '0;
                    end
                end
                SS_TT02: begin
                    if (link.ul_req) begin
                        state_ff  <= SS_TT03;
                        assign_ff <= 1'b1;
                        tmr_ff    <= '0;
                    end else if (tmr_ff == 16'(`RBL_TT02_CYC - 1)) begin
                        state_ff   <= SS_IDLE;
                        timeout_ff <= 1'b1;
                    end
                end
                SS_TT03: begin
                    if (tmr_ff == 16'(`RBL_TT03_CYC - 1)) state_ff <= SS_RUN;
                end
                SS_RUN: begin
                    if (release_test) begin
                        state_ff   <= SS_IDLE;
                        release_ff <= 1'b1;
                    end
                end
                default: state_ff <= SS_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // block period strobe and downlink blocks
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blk_cnt_ff <= '0;
        end else if (blk_cnt_ff == 16'(`RBL_BLK_CYC - 1)) begin
            blk_cnt_ff <= '0;
        end else begin
            blk_cnt_ff <= 16'(blk_cnt_ff + 16'h1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prbs_ff     <= `RBL_PRBS_SEED;
            dl_valid_ff <= 1'b0;
            dl_tn_ff    <= '0;
            dl_ctrl_ff  <= 1'b0;
            dl_ptype_ff <= '0;
            dl_data_ff  <= '0;
        end else begin
            dl_valid_ff <= tx_valid && tx_ready;
            if (tx_valid && tx_ready) begin
                dl_tn_ff    <= tx_tn;
                dl_ctrl_ff  <= tx_ctrl;
                dl_ptype_ff <= tx_ptype;
                if (tx_ctrl) begin
                    dl_data_ff <= tx_ctrl_data;
                end else begin
                    dl_data_ff <= {17'h00000, prbs_ff};
                    prbs_ff    <= prbs_step(prbs_ff);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loop_valid_ff  <= 1'b0;
            loop_tn_ff     <= '0;
            loop_looped_ff <= 1'b0;
            loop_data_ff   <= '0;
        end else begin
            loop_valid_ff <= link.ul_valid;
            if (link.ul_valid) begin
                loop_tn_ff     <= link.ul_tn;
                loop_looped_ff <= link.ul_looped;
                loop_data_ff   <= link.ul_data;
            end
        end
    end

    assign link.blk_tick    = blk_cnt_ff == 16'(`RBL_BLK_CYC - 1);
    assign link.start_cmd   = start_ff;
    assign link.ul_assign   = assign_ff;
    assign link.tbf_release = release_ff;
    assign link.dl_valid    = dl_valid_ff;
    assign link.dl_tn       = dl_tn_ff;
    assign link.dl_ctrl     = dl_ctrl_ff;
    assign link.dl_ptype    = dl_ptype_ff;
    assign link.dl_hdr_ok   = dl_valid_ff;
    assign link.dl_data     = dl_data_ff;
    assign tt02_timeout     = timeout_ff;
    assign loop_valid       = loop_valid_ff;
    assign loop_tn          = loop_tn_ff;
    assign loop_looped      = loop_looped_ff;
    assign loop_data        = loop_data_ff;
endmodule : rbl_ss

// File: tb/rbl_link_monitor.sv
// assertions watching the loopback link between the two ends
`timescale 1ns/1ps
module rbl_link_monitor
    import rbl_pkg::*;
(
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               blk_tick,
    input wire logic               start_cmd,
    input wire logic               ul_req,
    input wire logic               ul_assign,
    input wire logic               tbf_release,
    input wire logic               dl_valid,
    input wire logic               dl_ctrl,
    input wire rbl_pkg::rbl_word_t dl_data,
    input wire logic               ul_valid,
    input wire rbl_pkg::rbl_tn_t   ul_tn,
    input wire logic               ul_looped
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles since the last block tick; FF means none seen since reset
    logic [7:0] gap_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            gap_ff <= 8'hFF;
        else if (blk_tick)
            gap_ff <= 8'h01;
        else if (gap_ff != 8'hFF)
            gap_ff <= gap_ff + 8'h01;
    end
    start_req_a: assert property (start_cmd |=> ul_req) else $error("no request");
    req_assign_a: assert property (ul_req |=> ul_assign) else $error("no assign");
    assign_wait_a: assert property (ul_assign |=> !dl_valid [*8])
        else $error("downlink too early");
    blk_period_a: assert property (blk_tick && gap_ff != 8'hFF |-> gap_ff == 8'h80)
        else $error("block period wrong");
    loop_slot_a: assert property (ul_valid && ul_looped |-> gap_ff inside {[8'h02:8'h09]})
        else $error("loop outside next period");
    ul_order_a: assert property ((ul_valid && ul_looped) ##1 (ul_valid && ul_looped)
        |-> ul_tn > $past(ul_tn)) else $error("uplink slot order");
    release_stop_a: assert property (tbf_release |-> ##2 !ul_valid [*8])
        else $error("uplink after release");
    prbs_fill_a: assert property (dl_valid && !dl_ctrl |-> dl_data[31:15] == 17'h0)
        else $error("payload fill wrong");
endmodule : rbl_link_monitor

// File: tb/radio_block_loopback_control_bench.sv
// bench joining both ends of the loopback link back to back
`timescale 1ns/1ps
module radio_block_loopback_control_bench;
    import rbl_pkg::*;
    logic       clk = 0;
    logic       rstn = 0;
    logic       st, rl, txv, txc, t319, ownv, msen, oready, rv, ropt, llcv;
    logic       lact, son, tdis, pidle, txr, lv, ll;
    logic [7:0] seen;
    rbl_tn_t    txtn, ofs, ltn;
    rbl_ptype_t txpt;
    rbl_mask_t  dlm, ulm;
    rbl_word_t  txd, ownd, ld, rd;
    rbl_word_t  got [8];
    rbl_word_t  ex [8];
    int         fails = 0;
    int         compares = 0;
    int         nrv = 0;
    int         nopt = 0;
    int         nllc = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (rv === 1'h1) nrv++;
        if (rv === 1'h1 && ropt === 1'h1) nopt++;
        if (llcv === 1'h1) nllc++;
    end

    rbl_link_if lk (.clk(clk), .rstn(rstn));
    rbl_ms rbl_ms_i (.clk(clk), .rstn(rstn), .link(lk.ms), .dl_ts_mask(dlm), .ul_ts_mask(ulm),
        .ts_offset(ofs), .multislot_en(msen), .t3190_expired(t319), .own_valid(ownv),
        .own_data(ownd), .own_ready(oready), .rlcmac_valid(rv), .rlcmac_data(rd),
        .rlcmac_ctrl(), .rlcmac_opt(ropt), .llc_valid(llcv), .llc_data(), .loop_active(lact),
        .submode_on(son), .timers_disable(tdis), .packet_idle(pidle));
    rbl_ss rbl_ss_i (.clk(clk), .rstn(rstn), .link(lk.ss), .start_test(st), .release_test(rl),
        .tx_valid(txv), .tx_tn(txtn), .tx_ctrl(txc), .tx_ptype(txpt), .tx_ctrl_data(txd),
        .tx_ready(txr), .tt02_timeout(), .loop_valid(lv), .loop_tn(ltn), .loop_looped(ll),
        .loop_data(ld));
    rbl_link_monitor mon_i (.clk(clk), .rstn(rstn), .blk_tick(lk.blk_tick),
        .start_cmd(lk.start_cmd), .ul_req(lk.ul_req), .ul_assign(lk.ul_assign),
        .tbf_release(lk.tbf_release), .dl_valid(lk.dl_valid), .dl_ctrl(lk.dl_ctrl),
        .dl_data(lk.dl_data), .ul_valid(lk.ul_valid), .ul_tn(lk.ul_tn),
        .ul_looped(lk.ul_looped));

    // --------------------------------
    // shared tasks
    // --------------------------------
    task chk(input logic [31:0] a, input logic [31:0] e);
        compares++;
        if (a !== e) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, a, e);
        end
    endtask : chk

    // bounded wait, so a dead handshake ends as a mismatch
    task automatic till(ref logic s);
        int n = 0;
        while (s !== 1'h1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk(n < 1000, 1'h1);
    endtask : till

    task send(input rbl_tn_t tn, input rbl_ptype_t pt, input rbl_word_t d, input logic c);
        @(posedge clk);
        txv  <= 1'h1;
        txtn <= tn;
        txpt <= pt;
        txd  <= d;
        txc  <= c;
        @(posedge clk);
        while (txr !== 1'h1) @(posedge clk);
        txv <= 1'h0;
        till(lk.dl_valid);
        chk(lk.dl_tn, tn);
    endtask : send

    task loopchk(input logic [7:0] w);
        till(lk.blk_tick);
        seen = 8'h0;
        repeat (14) begin
            @(posedge clk);
            if (lv === 1'h1) begin
                seen[ltn] = 1'h1;
                got[ltn] = ld;
                chk(ll, 1'h1);
            end
        end
        chk(seen, w);
        for (int u = 0; u < 8; u++)
            if (w[u]) chk(got[u], ex[u]);
    endtask : loopchk

    // --------------------------------
    // scenarios
    // --------------------------------
    task t_start;
        @(posedge clk);
        st <= 1'h1;
        @(posedge clk);
        st <= 1'h0;
        till(txr);
        chk({son, tdis, lact, pidle}, 4'hE);
    endtask : t_start

    // offset 4 over slots 3..5 gives order 4,5,3; uplink 3 and 4 repeat slot 3
    task t_multi;
        msen <= 1'h1;
        dlm <= 8'h38;
        ofs <= 3'h4;
        ulm <= 8'h1F;
        ex = '{32'hA4, 32'hA5, 32'hA3, 32'hA3, 32'hA3, 32'h0, 32'h0, 32'h0};
        till(lk.blk_tick);
        send(3'h3, 2'h0, 32'hA3, 1'h1);
        send(3'h4, 2'h0, 32'hA4, 1'h1);
        send(3'h5, 2'h0, 32'hA5, 1'h1);
        loopchk(8'h1F);
        chk(nrv, 3);
        chk(rd, 32'hA5);
    endtask : t_multi

    task t_single;
        dlm <= 8'h04;
        ex = '{default: 32'hB2};
        till(lk.blk_tick);
        send(3'h2, 2'h0, 32'hB2, 1'h1);
        loopchk(8'h1F);
    endtask : t_single

    task t_off;
        dlm <= 8'h38;
        send(3'h3, 2'h1, 32'hD1, 1'h1);
        repeat (3) @(posedge clk);
        chk(son, 1'h0);
        ex = '{default: 32'hD1};
        loopchk(8'h1C);
        send(3'h3, 2'h3, 32'hD3, 1'h1);
        loopchk(8'h00);
        chk(son, 1'h0);
        ownd <= 32'hC0;
        ownv <= 1'h1;
        @(posedge clk);
        while (oready !== 1'h1) @(posedge clk);
        ownv <= 1'h0;
        till(lv);
        chk(ld, 32'hC0);
        chk({ll, ltn}, 4'h0);
        send(3'h4, 2'h2, 32'hE4, 1'h1);
        repeat (3) @(posedge clk);
        chk(son, 1'h1);
        chk(nopt, 1);
        send(3'h5, 2'h0, 32'h0, 1'h0);
    endtask : t_off

    task t_end;
        @(posedge clk);
        rl <= 1'h1;
        @(posedge clk);
        rl <= 1'h0;
        repeat (4) @(posedge clk);
        chk({pidle, son, lact, tdis}, 4'h8);
        chk(nllc, 0);
        t_start;
        t319 <= 1'h1;
        @(posedge clk);
        t319 <= 1'h0;
        repeat (3) @(posedge clk);
        chk({pidle, son}, 2'h2);
    endtask : t_end

    task conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    initial begin
        #100000;
        fails++;
        conclude;
    end

    initial begin
        {st, rl, txv, txc, t319, ownv, msen} = '0;
        {txtn, ofs, txpt, txd, ownd, dlm, ulm} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        t_start;
        t_multi;
        t_single;
        t_off;
        t_end;
        conclude;
    end
endmodule : radio_block_loopback_control_bench
